// [logic/itb_core.sv]
// Purpose: interrupt flags, enables, vectoring and two time bases
// Assumes: classic Wishbone slave, 8-bit registers in byte lane 0
// Notes: service is taken inside the block and shown on irq_o
`timescale 1ns/1ps
`include "itb_params.svh"

module itb_core import itb_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// external interrupt pins and slow clock pins
	input wire logic [3:0] pin_irq_i,
	input wire logic sub_clk_i,
	input wire logic fast_clk_i,
	// on-chip sources, same clock
	input wire logic [1:0] cmp_out_i,
	input wire itb_evt_s evt_i,
	// cpu side
	input wire logic stack_full_i,
	input wire logic sleep_i,
	output logic irq_o,
	output logic [3:0] irq_vec_o,
	output logic wake_o,
	output logic [3:0] pin_irq_enables_o
);

	// ==========================================================
	// state
	// ==========================================================
	// all registers of the block in one record
	typedef struct packed {
		logic [5:0] sy1; // first sync stage, pins and slow clocks
		logic [5:0] sy2; // second sync stage
		logic [5:0] sy3; // previous synced value for edges
		logic [1:0] cmp_prev; // last comparator levels
		logic [7:0] edge_sel; // edge_select_register
		logic global_irq_enable;
		logic [13:0] en; // per-source enables
		logic [13:0] flag; // per-source request flags
		logic [2:0] g3_flag; // spi, nvm write, low supply
		logic [2:0] g3_en;
		logic [3:0] g4_flag; // t5a, t5p, t4a, t4p
		logic [3:0] g4_en;
		logic [1:0] periodic_clock_select;
		logic [1:0] periodic_run;
		logic [2:0] periodic0_period_code;
		logic [2:0] periodic1_period_code;
		logic [1:0] div4; // system clock prescaler
		itb_bus_e st; // bus answer state
		logic [7:0] rdat; // read data held for the answer
		logic irq; // one-cycle service pulse
		logic [3:0] vec; // served source
		logic wake;
	} itb_state_s;

	itb_state_s q;
	itb_state_s d;
	logic [1:0] tb_ovf; // overflow pulses of both time bases
	logic tb_tick; // selected time-base clock pulse
	logic [13:0] set_w; // hardware set events of this cycle, seen by the checks

	// ==========================================================
	// time-base clock and dividers
	// ==========================================================
	// pick the time-base clock pulse
	always_comb begin
		unique case (itb_tbclk_e'(q.periodic_clock_select))
			TBCLK_SYS: tb_tick = 1'b1;
			TBCLK_SYS4: tb_tick = (q.div4 == 2'(`ITB_SYS_DIV - 1));
			TBCLK_SUB: tb_tick = q.sy2[4] & ~q.sy3[4];
			TBCLK_FAST: tb_tick = q.sy2[5] & ~q.sy3[5];
		endcase
	end

	// divider for time base 0
	itb_tbase u_tb0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tb_tick),
		.run_i(q.periodic_run[0]),
		.code_i(q.periodic0_period_code),
		.ovf_o(tb_ovf[0])
	);

	// divider for time base 1
	itb_tbase u_tb1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tb_tick),
		.run_i(q.periodic_run[1]),
		.code_i(q.periodic1_period_code),
		.ovf_o(tb_ovf[1])
	);

	// ==========================================================
	// helpers
	// ==========================================================
	// does a pin transition match its edge code
	function automatic logic pin_hit(input logic [1:0] sel, input logic prv,
		input logic cur);
		logic hit;
		hit = 1'b0;
		unique case (itb_edge_e'(sel))
			EDGE_OFF: hit = 1'b0;
			EDGE_RISE: hit = cur & ~prv;
			EDGE_FALL: hit = ~cur & prv;
			EDGE_BOTH: hit = cur ^ prv;
		endcase
		return hit;
	endfunction

	// register read image
	function automatic logic [7:0] rd_byte(input itb_state_s s,
		input logic [7:0] a);
		logic [7:0] r;
		r = `ITB_RST_BYTE;
		case (a)
			`ITB_OFS_EDGE: r = s.edge_sel;
			`ITB_OFS_CTL0: r = {1'b0, s.flag[SRC_CP0], s.flag[SRC_INT1],
				s.flag[SRC_INT0], s.en[SRC_CP0], s.en[SRC_INT1], s.en[SRC_INT0],
				s.global_irq_enable};
			`ITB_OFS_CTL1: r = {s.flag[SRC_CONV], s.flag[SRC_MF1], s.flag[SRC_MF0],
				s.flag[SRC_CP1], s.en[SRC_CONV], s.en[SRC_MF1], s.en[SRC_MF0],
				s.en[SRC_CP1]};
			`ITB_OFS_CTL2: r = {s.flag[SRC_MF3], s.flag[SRC_TB1], s.flag[SRC_TB0],
				s.flag[SRC_MF2], s.en[SRC_MF3], s.en[SRC_TB1], s.en[SRC_TB0],
				s.en[SRC_MF2]};
			`ITB_OFS_CTL3: r = {1'b0, s.flag[SRC_MF4], s.flag[SRC_INT3],
				s.flag[SRC_INT2], 1'b0, s.en[SRC_MF4], s.en[SRC_INT3],
				s.en[SRC_INT2]};
			`ITB_OFS_GRP3: r = {1'b0, s.g3_flag, 1'b0, s.g3_en};
			`ITB_OFS_GRP4: r = {s.g4_flag, s.g4_en};
			`ITB_OFS_TBCLK: r = {6'h00, s.periodic_clock_select};
			`ITB_OFS_TB0: r = {s.periodic_run[0], 4'h0, s.periodic0_period_code};
			`ITB_OFS_TB1: r = {s.periodic_run[1], 4'h0, s.periodic1_period_code};
			default: r = `ITB_RST_BYTE; // unmapped reads zero
		endcase
		return r;
	endfunction

	// ==========================================================
	// next state
	// ==========================================================
	always_comb begin
		logic [13:0] set; // hardware set events per source
		logic [13:0] pend; // enabled pending requests
		logic [2:0] s3; // group three member events
		logic [7:0] wd; // write byte
		logic wr; // write takes effect this edge
		logic svc; // service this edge
		logic [3:0] pick; // lowest pending source
		set = '0;
		pend = '0;
		s3 = '0;
		wd = wb_dat_i[7:0];
		wr = 1'b0;
		svc = 1'b0;
		pick = '0;
		d = q;

		// synchronise pins and slow clocks; sy1 feeds only sy2
		d.sy1 = {fast_clk_i, sub_clk_i, pin_irq_i};
		d.sy2 = q.sy1;
		d.sy3 = q.sy2;
		d.cmp_prev = cmp_out_i;
		d.div4 = q.div4 + 2'h1;

		// pin edges count only while the pin is enabled
		for (int i = 0; i < 4; i++) begin
			set[i] = q.en[i] & pin_hit(q.edge_sel[2*i +: 2], q.sy3[i], q.sy2[i]);
		end
		// comparator output change
		set[SRC_CP0] = cmp_out_i[0] ^ q.cmp_prev[0];
		set[SRC_CP1] = cmp_out_i[1] ^ q.cmp_prev[1];
		// grouped, converter and time-base sources
		s3 = {evt_i.spi_port, evt_i.nvm_write, evt_i.low_supply};
		set[SRC_MF0] = evt_i.grp_other[0];
		set[SRC_MF1] = evt_i.grp_other[1];
		set[SRC_MF2] = evt_i.grp_other[2];
		set[SRC_MF3] = |s3;
		set[SRC_MF4] = |evt_i.tm_match;
		set[SRC_CONV] = evt_i.conv_done;
		set[SRC_TB0] = tb_ovf[0];
		set[SRC_TB1] = tb_ovf[1];
		set_w = set;

		// bus: answer one cycle after the request, then drop
		wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (q.st == BUS_ACK);
		unique case (q.st)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					d.st = BUS_ACK;
					d.rdat = rd_byte(q, wb_adr_i);
				end
			end
			BUS_ACK: begin
				d.st = BUS_IDLE;
			end
		endcase

		// software writes
		if (wr) begin
			case (wb_adr_i)
				`ITB_OFS_EDGE: d.edge_sel = wd;
				`ITB_OFS_CTL0: {d.flag[SRC_CP0], d.flag[SRC_INT1], d.flag[SRC_INT0],
					d.en[SRC_CP0], d.en[SRC_INT1], d.en[SRC_INT0],
					d.global_irq_enable} = wd[6:0];
				`ITB_OFS_CTL1: {d.flag[SRC_CONV], d.flag[SRC_MF1], d.flag[SRC_MF0],
					d.flag[SRC_CP1], d.en[SRC_CONV], d.en[SRC_MF1], d.en[SRC_MF0],
					d.en[SRC_CP1]} = wd;
				`ITB_OFS_CTL2: {d.flag[SRC_MF3], d.flag[SRC_TB1], d.flag[SRC_TB0],
					d.flag[SRC_MF2], d.en[SRC_MF3], d.en[SRC_TB1], d.en[SRC_TB0],
					d.en[SRC_MF2]} = wd;
				`ITB_OFS_CTL3: begin
					{d.flag[SRC_MF4], d.flag[SRC_INT3], d.flag[SRC_INT2]} = wd[6:4];
					{d.en[SRC_MF4], d.en[SRC_INT3], d.en[SRC_INT2]} = wd[2:0];
				end
				`ITB_OFS_GRP3: begin
					d.g3_flag = wd[6:4];
					d.g3_en = wd[2:0];
				end
				`ITB_OFS_GRP4: begin
					d.g4_flag = wd[7:4];
					d.g4_en = wd[3:0];
				end
				`ITB_OFS_TBCLK: d.periodic_clock_select = wd[1:0];
				`ITB_OFS_TB0: begin
					d.periodic_run[0] = wd[`ITB_TB_RUN_BIT];
					d.periodic0_period_code = wd[2:0];
				end
				`ITB_OFS_TB1: begin
					d.periodic_run[1] = wd[`ITB_TB_RUN_BIT];
					d.periodic1_period_code = wd[2:0];
				end
				default: ; // unmapped writes are dropped
			endcase
		end

		// lowest enabled pending source wins
		pend = q.flag & q.en;
		for (int i = 13; i >= 0; i--) begin
			if (pend[i]) begin
				pick = 4'(i);
			end
		end
		svc = q.global_irq_enable & (|pend) & ~stack_full_i & ~q.irq;

		// service clears the served flag and the global enable
		d.irq = svc;
		if (svc) begin
			d.flag[pick] = 1'b0;
			d.global_irq_enable = 1'b0;
			d.vec = pick;
		end

		// hardware set wins over software or service clear
		d.flag = d.flag | set;
		d.g3_flag = d.g3_flag | s3;
		d.g4_flag = d.g4_flag | evt_i.tm_match;

		// wake on any rising flag, enables play no part
		d.wake = sleep_i & ((|(d.flag & ~q.flag)) | (|(d.g3_flag & ~q.g3_flag))
			| (|(d.g4_flag & ~q.g4_flag)));
	end

	// ==========================================================
	// state register
	// ==========================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign wb_dat_o = {24'h000000, q.rdat};
	assign wb_ack_o = q.st;
	assign irq_o = q.irq;
	assign irq_vec_o = q.vec;
	assign wake_o = q.wake;
	assign pin_irq_enables_o = q.en[3:0];

	// ==========================================================
	// checks
	// ==========================================================
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// a request seen with all gates open
	sequence s_gates_open;
		q.global_irq_enable && (|(q.flag & q.en)) && !stack_full_i && !q.irq;
	endsequence

	// a time base held stopped for two cycles
	sequence s_tb0_stopped;
		!q.periodic_run[0] [*2];
	endsequence

	a_gate_vectors: assert property (s_gates_open |=> q.irq)
		else $error("open gates did not vector");
	a_stack_block: assert property (q.irq |-> $past(!stack_full_i)
		&& $past(q.global_irq_enable))
		else $error("vectored while stack full or disabled");
	a_svc_clr_emi: assert property (q.irq |-> !q.global_irq_enable)
		else $error("service left global enable set");
	a_svc_clr_flag: assert property (q.irq |-> !q.flag[q.vec]
		|| (|($past(set_w) & (14'h1 << q.vec))))
		else $error("service left request flag set");
	a_pin_rise: assert property (q.sy2[0] && !q.sy3[0] && q.en[0]
		&& q.edge_sel[1:0] == 2'h1 |=> q.flag[0])
		else $error("rising edge did not set pin flag");
	a_pin_off: assert property (!q.en[1] && !q.flag[1] && !wr_ctl0() |=>
		!q.flag[1])
		else $error("disabled pin set its flag");
	a_cmp_change: assert property (cmp_out_i[1] != q.cmp_prev[1] |=>
		q.flag[SRC_CP1])
		else $error("comparator change lost");
	a_grp_set: assert property (evt_i.low_supply |=> q.flag[SRC_MF3]
		&& q.g3_flag[0])
		else $error("group three flag not set");
	a_conv_set: assert property (evt_i.conv_done |=> q.flag[SRC_CONV])
		else $error("conversion end lost");
	a_tb_stop: assert property (s_tb0_stopped |-> !tb_ovf[0])
		else $error("stopped time base overflowed");
	a_tb_flag: assert property (tb_ovf[1] |=> q.flag[SRC_TB1])
		else $error("time base overflow lost");
	a_prio_low: assert property (q.irq |-> ($past(q.flag & q.en)
		& ((14'h1 << q.vec) - 14'h1)) == 14'h0)
		else $error("lower vector was pending");
	a_wake_rise: assert property ($rose(q.flag[SRC_MF3]) && $past(sleep_i)
		|-> q.wake)
		else $error("flag rise in sleep did not wake");
	a_tbclk_rsv: assert property (q.st == BUS_ACK && !wb_we_i
		&& wb_adr_i == `ITB_OFS_TBCLK |-> q.rdat[7:2] == 6'h00)
		else $error("clock select upper bits not zero");

	// a control register zero write in flight
	function automatic logic wr_ctl0();
		return wb_cyc_i & wb_stb_i & wb_we_i & (q.st == BUS_ACK)
			& (wb_adr_i == `ITB_OFS_CTL0);
	endfunction

endmodule

// [logic/itb_params.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: included by its bare name from the package and the modules
// Notes: definitions only
//
// What this block does
// - pin flag set on selected edge type
// - pin vectors only with global and own enable
// - pin acts as interrupt only while enabled
// - pin service clears its flag and global enable
// - edge code 00 off, 01 rise, 10 fall, 11 both
// - comparator flag set on any output change
// - vector only when enabled and stack not full
// - five grouped interrupts collect peripheral sources
// - group flag set when any member flag sets
// - group service clears group flag and global enable
// - converter flag set when conversion finishes
// - converter service clears its flag and global enable
// - time-base flag set on each divider overflow
// - time-base service clears its flag and global enable
// - clock select 00 sys, 01 sys/4, 10 sub, 11 fast
// - time base 0 runs only while bit 7 set
// - time base 0 period is 2^(8+code) clocks
// - time base 1 has own enable and period code
// - group three flags bits 6-4, enables 2-0
// - group four flags bits 7-4, enables 3-0
// - unused clock select bits read zero
// - sleep wake on any flag rise, enables ignored
`ifndef ITB_PARAMS_SVH
`define ITB_PARAMS_SVH

// register byte offsets on the bus
`define ITB_OFS_EDGE 8'h00
`define ITB_OFS_CTL0 8'h04
`define ITB_OFS_CTL1 8'h08
`define ITB_OFS_CTL2 8'h0C
`define ITB_OFS_CTL3 8'h10
`define ITB_OFS_GRP3 8'h14
`define ITB_OFS_GRP4 8'h18
`define ITB_OFS_TBCLK 8'h1C
`define ITB_OFS_TB0 8'h20
`define ITB_OFS_TB1 8'h24

// reset value of every register
`define ITB_RST_BYTE 8'h00
// run bit of a time-base control register
`define ITB_TB_RUN_BIT 7
// period exponent base and counter width
`define ITB_TB_EXP_BASE 8
`define ITB_TB_CNT_W 15
// system clock prescale for clock select 01
`define ITB_SYS_DIV 4

`endif

// [logic/itb_pkg.sv]
// Purpose: types shared by the interrupt and time-base unit
// Assumes: itb_params.svh supplies widths
// Notes: sources are numbered in vector order
`include "itb_params.svh"

package itb_pkg;

	// edge select codes of a pin
	typedef enum logic [1:0] {
		EDGE_OFF = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_FALL = 2'h2,
		EDGE_BOTH = 2'h3
	} itb_edge_e;

	// time-base clock source codes
	typedef enum logic [1:0] {
		TBCLK_SYS = 2'h0,
		TBCLK_SYS4 = 2'h1,
		TBCLK_SUB = 2'h2,
		TBCLK_FAST = 2'h3
	} itb_tbclk_e;

	// interrupt sources, lowest value served first
	typedef enum logic [3:0] {
		SRC_INT0 = 4'h0, SRC_INT1 = 4'h1, SRC_INT2 = 4'h2, SRC_INT3 = 4'h3,
		SRC_CP0 = 4'h4, SRC_CP1 = 4'h5, SRC_MF0 = 4'h6, SRC_MF1 = 4'h7,
		SRC_MF2 = 4'h8, SRC_MF3 = 4'h9, SRC_MF4 = 4'hA, SRC_CONV = 4'hB,
		SRC_TB0 = 4'hC, SRC_TB1 = 4'hD
	} itb_src_e;

	// bus answer state
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} itb_bus_e;

	// one-cycle peripheral events
	typedef struct packed {
		logic conv_done;
		logic spi_port;
		logic nvm_write;
		logic low_supply;
		logic [3:0] tm_match;
		logic [2:0] grp_other;
	} itb_evt_s;

	// time-base divider state
	typedef struct packed {
		logic [`ITB_TB_CNT_W-1:0] cnt;
		logic ovf;
	} itb_tb_s;

endpackage

// [logic/itb_tbase.sv]
// Purpose: one time-base divider with a power-of-two period
// Assumes: tick_i is a one-cycle pulse at the time-base clock rate
// Notes: ovf_o pulses one cycle after the terminal tick
`timescale 1ns/1ps
`include "itb_params.svh"

module itb_tbase import itb_pkg::*; #(
	parameter int CNT_W = `ITB_TB_CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic [2:0] code_i,
	output logic ovf_o
);

	// the top code needs exactly this many counter bits
	if (CNT_W != `ITB_TB_EXP_BASE + 7) begin : g_chk
		$error("itb_tbase: CNT_W must cover the longest period");
	end

	itb_tb_s q;
	itb_tb_s d;
	logic [15:0] lim;

	// terminal count 2^(base+code)-1
	assign lim = (16'h1 << (`ITB_TB_EXP_BASE + 32'(code_i))) - 16'h1;

	// count ticks while running, clear when stopped
	always_comb begin
		d = q;
		d.ovf = 1'b0;
		if (!run_i) begin
			d.cnt = '0;
		end else if (tick_i) begin
			if (q.cnt == lim[CNT_W-1:0]) begin
				d.cnt = '0;
				d.ovf = 1'b1;
			end else begin
				d.cnt = q.cnt + 15'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ovf_o = q.ovf;

endmodule

// [dv/itb_periph_model.sv]
// Purpose: peripheral event sources and comparators beside the unit
// Assumes: the bench asks for events one cycle at a time
// Notes: events leave as one-cycle pulses on the system clock
`timescale 1ns/1ps

module itb_periph_model import itb_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire itb_evt_s req_i,
	input wire logic req_stb_i,
	input wire logic [1:0] cmp_tgl_i,
	output itb_evt_s evt_o,
	output logic [1:0] cmp_o
);
	// ========================================
	// event pulses and comparator levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_o <= '0;
			cmp_o <= 2'h0;
		end else begin
			// a pulse lasts exactly one cycle, never a level
			evt_o <= req_stb_i ? req_i : '0;
			cmp_o <= cmp_o ^ cmp_tgl_i;
		end
	end
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench of the interrupt and time-base unit
// Assumes: reads and services are noted in queues before they happen
// Notes: a monitor pops the oldest note whenever a result appears
`timescale 1ns/1ps

module testbench import itb_pkg::*; ;
	logic clk_i, rst_i, cyc, stb, we, sub, fast, stk, slp, rstb, irq, wake, ack;
	logic [7:0] adr;
	logic [3:0] sel, pin, vec, pen;
	logic [31:0] wdat, rdat;
	logic [1:0] tgl, cmp;
	itb_evt_s req, evt, ev;
	logic [31:0] dq[$];
	logic [3:0] vq[$];
	int fail_count, num_checks, cyc_n, wake_cnt, t1, w0;
	logic [7:0] r;
	int mul[4] = '{1, 4, 4, 8};

	itb_periph_model i_itb_periph_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.req_stb_i(rstb), .cmp_tgl_i(tgl), .evt_o(evt), .cmp_o(cmp));
	itb_core i_itb_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pin_irq_i(pin), .sub_clk_i(sub), .fast_clk_i(fast),
		.cmp_out_i(cmp), .evt_i(evt), .stack_full_i(stk), .sleep_i(slp), .irq_o(irq),
		.irq_vec_o(vec), .wake_o(wake), .pin_irq_enables_o(pen));

	// ========================================
	// clock, slow clock pins and timeout
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		sub <= cyc_n[1];
		fast <= cyc_n[2];
		if (cyc_n == 40000) begin
			fail_count++;
			finish_test();
		end
	end

	// ========================================
	// compare tasks and verdict
	task automatic chk_dat(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: data %h, want %h", $time, g, e);
		end
	endtask
	task automatic chk_vec(input logic [3:0] g, input logic [3:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: vector %h, want %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && num_checks > 0 && dq.size() == 0 && vq.size() == 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ========================================
	// monitor: each answer takes the oldest note
	always @(posedge clk_i) begin
		if (!rst_i && ack === 1'b1 && we === 1'b0) begin
			if (dq.size() == 0) chk_dat(rdat, 32'hFFFFFFFF);
			else chk_dat(rdat, dq.pop_front());
		end
		if (!rst_i && irq === 1'b1) begin
			// a service nobody expected is a mismatch
			if (vq.size() == 0) chk_vec(vec, 4'hF);
			else chk_vec(vec, vq.pop_front());
		end
		if (wake === 1'b1) wake_cnt++;
	end

	// ========================================
	// wishbone classic single cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk_dat(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		dq.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic poke(input itb_evt_s e, input logic [1:0] t);
		@(posedge clk_i);
		req <= e;
		rstb <= 1'b1;
		tgl <= t;
		@(posedge clk_i);
		rstb <= 1'b0;
		tgl <= 2'h0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (irq !== 1'b1 && n < 5000);
		if (n >= 5000) chk_dat(32'h0, 32'h2);
	endtask
	// one time base: two overflows, interval in system cycles
	task automatic tb_per(input logic [7:0] a, input logic [7:0] c, input logic [1:0] s,
		input logic [3:0] v, input int exp);
		wr(8'h1C, {6'h0, s});
		vq.push_back(v);
		vq.push_back(v);
		wr(a, c);
		wr(8'h04, 8'h01);
		wait_irq();
		t1 = cyc_n;
		wr(8'h04, 8'h01);
		wait_irq();
		chk_dat(cyc_n - t1, exp);
		wr(a, 8'h00);
	endtask

	// ========================================
	// main sequence
	initial begin
		{cyc, stb, we, stk, slp, rstb, sub, fast} = '0;
		{adr, sel, pin, wdat, tgl, req} = '0;
		{fail_count, num_checks, cyc_n, wake_cnt} = '0;
		rst_i = 1'b1;
		r = 8'($urandom(32'h75482fea));
		idle(16);
		rst_i <= 1'b0;
		idle(2);
		for (int a = 0; a <= 8'h28; a += 4) rd(a[7:0], 8'h00);
		wr(8'h28, 8'hFF);
		rd(8'h28, 8'h00);
		r = 8'($urandom);
		wr(8'h00, r);
		rd(8'h00, r);
		wr(8'h1C, 8'hFF);
		rd(8'h1C, 8'h03);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h87);
		wr(8'h24, 8'hFF);
		rd(8'h24, 8'h87);
		wr(8'h14, 8'h07);
		rd(8'h14, 8'h07);
		wr(8'h18, 8'h0F);
		rd(8'h18, 8'h0F);
		r = 8'h00;
		pin <= 4'h0;
		for (int a = 0; a <= 8'h24; a += 4) wr(a[7:0], 8'h00);
		// every edge code on pin 0, rise then fall
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, c[7:0]);
			wr(8'h04, 8'h02);
			pin <= 4'h1;
			idle(8);
			chk_vec(pen, 4'h1);
			rd(8'h04, {3'h0, c[0], 4'h2});
			wr(8'h04, 8'h02);
			pin <= 4'h0;
			idle(8);
			rd(8'h04, {3'h0, c[1], 4'h2});
		end
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h0F);
		pin <= 4'h3;
		idle(8);
		rd(8'h04, 8'h00);
		pin <= 4'h0;
		wr(8'h00, 8'h01);
		wr(8'h04, 8'h03);
		vq.push_back(4'h0);
		pin <= 4'h1;
		wait_irq();
		rd(8'h04, 8'h02);
		wr(8'h04, 8'h00);
		// comparator changes both ways
		poke('0, 2'h1);
		idle(4);
		rd(8'h04, 8'h40);
		wr(8'h04, 8'h00);
		poke('0, 2'h3);
		idle(4);
		rd(8'h04, 8'h40);
		rd(8'h08, 8'h10);
		wr(8'h04, 8'h00);
		wr(8'h08, 8'h00);
		// stack full holds off a converter service
		stk <= 1'b1;
		wr(8'h08, 8'h08);
		wr(8'h04, 8'h01);
		ev = '0;
		ev.conv_done = 1'b1;
		poke(ev, 2'h0);
		idle(10);
		rd(8'h08, 8'h88);
		vq.push_back(4'hB);
		stk <= 1'b0;
		wait_irq();
		rd(8'h08, 8'h08);
		rd(8'h04, 8'h00);
		// each group, one member event at a time
		wr(8'h08, 8'h06);
		wr(8'h0C, 8'h09);
		wr(8'h10, 8'h04);
		for (int g = 0; g < 5; g++) begin
			ev = '0;
			if (g < 3) ev.grp_other = 3'(1 << g);
			else if (g == 3) ev.spi_port = 1'b1;
			else ev.tm_match = 4'(1 << ($urandom % 4));
			poke(ev, 2'h0);
			vq.push_back(4'(6 + g));
			wr(8'h04, 8'h01);
			wait_irq();
		end
		rd(8'h14, 8'h40);
		rd(8'h18, {ev.tm_match, 4'h0});
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h00);
		rd(8'h10, 8'h04);
		// two pending: lower vector first
		wr(8'h08, 8'h08);
		ev = '0;
		ev.conv_done = 1'b1;
		ev.tm_match = 4'h2;
		poke(ev, 2'h0);
		vq.push_back(4'hA);
		vq.push_back(4'hB);
		wr(8'h04, 8'h01);
		wait_irq();
		wr(8'h04, 8'h01);
		wait_irq();
		wr(8'h18, 8'h00);
		// wake while asleep, global enable off
		wr(8'h08, 8'h00);
		slp <= 1'b1;
		w0 = wake_cnt;
		ev = '0;
		ev.low_supply = 1'b1;
		poke(ev, 2'h0);
		idle(5);
		chk_dat(wake_cnt - w0, 1);
		slp <= 1'b0;
		wr(8'h14, 8'h00);
		wr(8'h10, 8'h00);
		// time base 0 over every clock source, time base 1 on sys only
		wr(8'h0C, 8'h02);
		for (int s = 0; s < 4; s++) tb_per(8'h20, 8'h80, s[1:0], 4'hC, 256 * mul[s]);
		wr(8'h0C, 8'h04);
		tb_per(8'h24, 8'h81, 2'h0, 4'hD, 512);
		wr(8'h04, 8'h01);
		idle(600);
		finish_test();
	end
endmodule
